// >>> dv/bcr_link_sva.sv
// checker on the link between the controller and the bridge
// assumes one clock; it takes the link signals as plain inputs
`timescale 1ns/1ps
`default_nettype none
module bcr_link_sva import bcr_pkg::*; #(
	parameter int RESET_CYC = 20 // enable low and pll waits
) (
	input  wire logic       pclk,     // system clock
	input  wire logic       presetn,  // async reset, low
	input  wire logic       en,       // enable pin
	input  wire logic       req,      // register request
	input  wire logic       we,       // write when high
	input  wire logic [7:0] addr,     // register offset
	input  wire logic [7:0] wdata,    // write data
	input  wire logic       ack,      // register answer
	input  wire logic       clk_hs,   // clock lane in high speed
	input  wire logic [1:0] lane,     // data lane state
	input  wire logic       vid_valid // video word valid
);
	// ---------------------------------------------------------------
	// helper counters and properties
	// ---------------------------------------------------------------
	logic       wr;
	logic [2:0] cfg_seen;
	int         lo_cnt;
	int         pll_cnt;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = en && req && we && !ack;
	// enable-low time, time since pll enable, clock settings written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_cnt <= 0;
			pll_cnt <= 0;
			cfg_seen <= 3'h0;
		end else begin
			lo_cnt <= en ? 0 : lo_cnt + 1;
			pll_cnt <= (wr && addr == A_PLL) ? 0 : pll_cnt + 1;
			cfg_seen <= !en ? 3'h0 : cfg_seen | {wr && addr == A_DSIRNG,
				wr && addr == A_CLKDIV, wr && addr == A_CLKSRC};
		end
	end
	a_ack_one_shot: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_ack_follows: assert property (en && req && !ack |=> ack)
		else $error("register request not answered");
	a_silent_reset: assert property (!en |-> !ack && !vid_valid)
		else $error("link active while enable low");
	a_en_low_time: assert property ($rose(en) |-> lo_cnt >= RESET_CYC)
		else $error("enable low too short");
	a_en_rise_lanes: assert property ($rose(en) |-> $past(clk_hs) &&
		$past(lane) == LN_LP11) else $error("lanes not ready at enable");
	a_pll_after_cfg: assert property (wr && addr == A_PLL &&
		wdata[PLL_BIT] |-> &cfg_seen) else $error("pll enabled too early");
	a_srst_wait: assert property (wr && addr == A_SRST &&
		wdata[SRST_BIT] |-> pll_cnt >= RESET_CYC) else $error("pll wait short");
	a_video_in_hs: assert property (vid_valid |-> lane == LN_HS && clk_hs)
		else $error("video outside high speed");
	a_ulps_clk_off: assert property (lane == LN_ULPS |-> !clk_hs)
		else $error("clock lane running in ulps");
	a_clear_value: assert property (wr && addr == A_ERR |-> wdata == ERR_CLR)
		else $error("error clear value wrong");
	c_en_rise: cover property ($rose(en));
	c_ulps: cover property (lane == LN_ULPS);
	c_err_clear: cover property (wr && addr == A_ERR);
endmodule
`default_nettype wire

// >>> dv/bridge_clock_reset_init_control_test.sv
// testbench: controller and bridge joined by the link interface
// assumes shortened waits of 20, 10, 15 and 5 cycles
`timescale 1ns/1ps
`default_nettype none
module bridge_clock_reset_init_control_test;
	import bcr_pkg::*;
	// ---------------------------------------------------------------
	// stimulus, instances and access tasks
	// ---------------------------------------------------------------
	logic        pclk = 1'b0, presetn = 1'b0, ref_clk = 1'b0, dsi_clk = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vid_in_v = 1'b0;
	logic [7:0]  paddr = 8'h00, err_in = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [23:0] vid_in_d = 24'h0, lvds_data;
	logic [2:0]  lvds_mult;
	logic        pready, pslverr, err, lvds_oe_n, bridge_on;
	logic        clk_en = 1'b1, lvds_tick, lvds_de;
	logic [15:0] tab [4] = '{16'h0A03, 16'h0B0A, 16'h1220, 16'h2040};
	int          n_errors = 0, checks = 0, cyc = 0, n_tick = 0, t0;
	bcr_link_if u_bcr_link_if ();
	bcr_ctrl #(.RESET_CYC(20), .ULPS_CYC(10), .VIDEO_CYC(15), .ERR_CYC(5))
	u_bcr_ctrl (.lnk(u_bcr_link_if), .pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vid_in_v(vid_in_v), .vid_in_d(vid_in_d),
		.err_in(err_in));
	bcr_bridge u_bcr_bridge (.lnk(u_bcr_link_if), .pclk(pclk),
		.presetn(presetn), .clk_en(clk_en), .ref_clk(ref_clk),
		.dsi_clk(dsi_clk), .lvds_tick(lvds_tick), .lvds_mult(lvds_mult),
		.lvds_de(lvds_de),
		.lvds_hs(), .lvds_vs(), .lvds_data(lvds_data),
		.lvds_oe_n(lvds_oe_n), .bridge_on(bridge_on));
	bcr_link_sva #(.RESET_CYC(20)) u_bcr_link_sva (.pclk(pclk),
		.presetn(presetn), .en(u_bcr_link_if.en), .req(u_bcr_link_if.req),
		.we(u_bcr_link_if.we), .addr(u_bcr_link_if.addr),
		.wdata(u_bcr_link_if.wdata), .ack(u_bcr_link_if.ack),
		.clk_hs(u_bcr_link_if.clk_hs), .lane(u_bcr_link_if.lane),
		.vid_valid(u_bcr_link_if.vid_valid));
	// clock, cycle count and pin clocks
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		{dsi_clk, ref_clk} <= {dsi_clk, ref_clk} + 2'h1;
		n_tick <= n_tick + int'(lvds_tick);
	end
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// poll the state word until a bit of the mask shows
	task automatic wait_st(input logic [31:0] m);
		do apb(1'b0, R_STAT, 32'h0); while ((rd & m) == 32'h0);
	endtask
	task automatic stop_test;
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence: boot with error retry, video, ulps round trip
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, R_STAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 4; i++)
			apb(1'b1, R_TAB + 8'(4 * i), {16'h0, tab[i]});
		apb(1'b1, R_CFG, 32'h104);
		err_in <= 8'h04;
		apb(1'b1, R_CTRL, 32'h1);
		wait_st(32'h4);
		chk({31'h0, lvds_oe_n}, 32'h1);
		chk({31'h0, bridge_on}, 32'h0);
		do apb(1'b0, R_STAT, 32'h0); while (rd[31:24] == 8'h00);
		err_in <= 8'h00;
		wait_st(32'h2000);
		chk({31'h0, bridge_on}, 32'h1);
		chk({31'h0, lvds_oe_n}, 32'h0);
		chk({29'h0, lvds_mult}, 32'h3);
		apb(1'b0, R_ERRRD, 32'h0);
		chk(rd, 32'h0);
		vid_in_v <= 1'b1;
		vid_in_d <= 24'hA5C3E1;
		t0 = n_tick;
		repeat (8) @(posedge pclk);
		chk(n_tick - t0, 32'h2);
		chk({8'h0, lvds_data}, 32'h00A5C3E1);
		chk({31'h0, lvds_de}, 32'h1);
		// clock enable low must hold the video path still
		clk_en <= 1'b0;
		vid_in_d <= 24'h5A3C1E;
		repeat (4) @(posedge pclk);
		chk({8'h0, lvds_data}, 32'h00A5C3E1);
		clk_en <= 1'b1;
		apb(1'b1, R_CTRL, 32'h2);
		wait_st(32'h4000);
		chk({31'h0, bridge_on}, 32'h0);
		t0 = cyc;
		apb(1'b1, R_CTRL, 32'h4);
		wait_st(32'h2000);
		chk({31'h0, cyc - t0 >= 10}, 32'h1);
		chk({31'h0, bridge_on}, 32'h1);
		stop_test();
	end
	// watchdog against a hung sequence
	initial begin
		repeat (50000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire

// >>> rtl/bcr_bridge.sv
// bridge side: register file, clock selection, bridging gate,
// error flags and test pattern generator
// assumes the controller shares pclk; clock inputs arrive from pins
`timescale 1ns/1ps
`default_nettype none
module bcr_bridge (
	bcr_link_if.dev          lnk,       // link to controller
	input  wire logic        pclk,      // system clock
	input  wire logic        presetn,   // async reset, low
	input  wire logic        clk_en,    // freezes state when low
	input  wire logic        ref_clk,   // external reference clock
	input  wire logic        dsi_clk,   // dsi channel a clock
	output logic             lvds_tick, // lvds clock event
	output logic [2:0]       lvds_mult, // reference multiplier
	output logic             lvds_de,   // data enable
	output logic             lvds_hs,   // hsync
	output logic             lvds_vs,   // vsync
	output logic [23:0]      lvds_data, // pixel data
	output logic             lvds_oe_n, // high when outputs float
	output logic             bridge_on  // bridging active
);
	import bcr_pkg::*;
	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	function automatic logic [7:0] reg_mask(input logic [7:0] a);
		case (a)
			A_CLKSRC: reg_mask = 8'h0F;
			A_CLKDIV: reg_mask = 8'hFB;
			A_PLL, A_SRST: reg_mask = 8'h01;
			A_HLEN_H, A_VSIZE_H: reg_mask = 8'h0F;
			A_HSW_H, A_VSW_H: reg_mask = 8'h03;
			A_DSIRNG, A_HLEN_L, A_VSIZE_L, A_HSW_L, A_VSW_L,
			A_HBP, A_VBP, A_HFP, A_VFP: reg_mask = 8'hFF;
			A_TPG: reg_mask = 8'h13;
			default: reg_mask = 8'h00;
		endcase
	endfunction
	logic [7:0] regs [0:63];
	logic [7:0] err_reg;
	logic       ack_reg;
	logic [7:0] rdata_reg;
	logic [2:0] seen_reg;
	logic       on_reg;
	logic       take, wr, srst, tpg;
	assign take = lnk.en & lnk.req & ~ack_reg;
	assign wr   = take & lnk.we;
	assign srst = wr & (lnk.addr == A_SRST) & lnk.wdata[SRST_BIT];
	assign tpg  = regs[A_TPG[5:0]][TPG_EN];
	assign lnk.ack   = ack_reg;
	assign lnk.rdata = rdata_reg;
	assign bridge_on = on_reg;
	// register port: writable and readable in any lane state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 64; i++) regs[i] <= RST_BYTE;
		end else if (clk_en) begin
			if (!lnk.en) begin
				for (int i = 0; i < 64; i++) regs[i] <= RST_BYTE;
			end else if (wr && lnk.addr < 8'h40 && lnk.addr != A_SRST) begin
				regs[lnk.addr[5:0]] <= lnk.wdata & reg_mask(lnk.addr);
			end
		end
	end
	// answer and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg   <= 1'b0;
			rdata_reg <= RST_BYTE;
		end else if (clk_en) begin
			ack_reg <= take;
			if (take && !lnk.we) begin
				if (lnk.addr == A_ERR)
					rdata_reg <= err_reg;
				else if (lnk.addr < 8'h40)
					rdata_reg <= regs[lnk.addr[5:0]] & reg_mask(lnk.addr);
				else
					rdata_reg <= RST_BYTE;
			end
		end
	end
	// error flags: an event beats a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg <= RST_BYTE;
		end else if (clk_en) begin
			if (!lnk.en)
				err_reg <= RST_BYTE;
			else if (wr && lnk.addr == A_ERR)
				err_reg <= (err_reg & ~lnk.wdata) | lnk.dsi_err;
			else
				err_reg <= err_reg | lnk.dsi_err;
		end
	end
	// bridging waits for configuration, pll and soft reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_reg <= 3'h0;
			on_reg   <= 1'b0;
		end else if (clk_en) begin
			if (!lnk.en) begin
				seen_reg <= 3'h0;
				on_reg   <= 1'b0;
			end else begin
				if (wr && lnk.addr == A_CLKSRC) seen_reg[0] <= 1'b1;
				if (wr && lnk.addr == A_CLKDIV) seen_reg[1] <= 1'b1;
				if (wr && lnk.addr == A_DSIRNG) seen_reg[2] <= 1'b1;
				if (lnk.lane == LN_ULPS)
					on_reg <= 1'b0;
				else if (srst)
					on_reg <= &seen_reg & regs[A_PLL[5:0]][PLL_BIT];
			end
		end
	end
	// ---------------------------------------------------------------
	// clock selection
	// ---------------------------------------------------------------
	logic [1:0] s1, s2, s3;
	logic [4:0] div_cnt;
	logic [4:0] div;
	logic       ref_e, dsi_e, src_dsi, pll_on;
	assign ref_e   = s2[0] & ~s3[0];
	assign dsi_e   = s2[1] & ~s3[1];
	assign src_dsi = regs[A_CLKSRC[5:0]][SRC_BIT] == SRC_DSI;
	assign pll_on  = regs[A_PLL[5:0]][PLL_BIT] & lnk.en;
	assign div     = regs[A_CLKDIV[5:0]][DIV_LSB +: 5];
	// clock pins pass two flops before edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 2'h0;
			s2 <= 2'h0;
			s3 <= 2'h0;
		end else if (clk_en) begin
			s1 <= {dsi_clk, ref_clk};
			s2 <= s1;
			s3 <= s2;
		end
	end
	// lvds clock from the reference or the divided dsi clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt   <= 5'h00;
			lvds_tick <= 1'b0;
			lvds_mult <= 3'h0;
		end else if (clk_en) begin
			lvds_mult <= {1'b0, regs[A_CLKDIV[5:0]][MULT_LSB +: 2]}
				+ 3'h1;
			lvds_tick <= 1'b0;
			if (!pll_on) begin
				div_cnt <= 5'h00;
			end else if (!src_dsi) begin
				lvds_tick <= ref_e;
			end else if (dsi_e) begin
				if (div_cnt + 5'h01 >= div) begin
					div_cnt   <= 5'h00;
					lvds_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 5'h01;
				end
			end
		end
	end
	// ---------------------------------------------------------------
	// pattern generator and output stage
	// ---------------------------------------------------------------
	logic [12:0] h, v, hs_w, vs_w, h_a, v_a, h_e, v_e, h_t, v_t;
	logic [23:0] pat;
	assign hs_w = {3'h0, regs[A_HSW_H[5:0]][1:0], regs[A_HSW_L[5:0]]};
	assign vs_w = {3'h0, regs[A_VSW_H[5:0]][1:0], regs[A_VSW_L[5:0]]};
	assign h_a  = hs_w + {5'h00, regs[A_HBP[5:0]]};
	assign v_a  = vs_w + {5'h00, regs[A_VBP[5:0]]};
	assign h_e  = h_a + {1'b0, regs[A_HLEN_H[5:0]][3:0],
		regs[A_HLEN_L[5:0]]};
	assign v_e  = v_a + {1'b0, regs[A_VSIZE_H[5:0]][3:0],
		regs[A_VSIZE_L[5:0]]};
	assign h_t  = h_e + {5'h00, regs[A_HFP[5:0]]};
	assign v_t  = v_e + {5'h00, regs[A_VFP[5:0]]};
	// three modes: bars, checkerboard, grey ramp
	always_comb begin
		case (regs[A_TPG[5:0]][TPG_M_LSB +: 2])
			2'h1: pat = (h[4] ^ v[4]) ? 24'hFFFFFF : 24'h000000;
			2'h2: pat = {h[7:0], h[7:0], h[7:0]};
			default: pat = {{8{h[7]}}, {8{h[6]}}, {8{h[5]}}};
		endcase
	end
	// frame counters and the lvds output registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h <= 13'h0000;
			v <= 13'h0000;
			lvds_de <= 1'b0;
			lvds_hs <= 1'b0;
			lvds_vs <= 1'b0;
			lvds_data <= 24'h000000;
			lvds_oe_n <= 1'b1;
		end else if (clk_en) begin
			lvds_oe_n <= ~lnk.en;
			if (!lnk.en || !(tpg || on_reg)) begin
				h <= 13'h0000;
				v <= 13'h0000;
				lvds_de <= 1'b0;
				lvds_hs <= 1'b0;
				lvds_vs <= 1'b0;
				lvds_data <= 24'h000000;
			end else if (tpg) begin
				if (lvds_tick) begin
					h <= (h + 13'h0001 >= h_t) ? 13'h0000 : h + 13'h0001;
					if (h + 13'h0001 >= h_t)
						v <= (v + 13'h0001 >= v_t) ? 13'h0000 : v + 13'h0001;
					lvds_hs <= h < hs_w;
					lvds_vs <= v < vs_w;
					lvds_de <= h >= h_a && h < h_e && v >= v_a && v < v_e;
					lvds_data <= pat;
				end
			end else begin
				lvds_de   <= lnk.vid_valid;
				lvds_data <= lnk.vid_valid ? lnk.vid_data : 24'h000000;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bcr_ctrl.sv
// initialization controller: runs the power-up, ulps exit and
// error check sequences over the link, ordered by apb registers
// assumes an apb master on pclk; the bridge shares pclk
// Function
// - bridge clock from dsi or reference
// - dsi clock lane kept in high speed
// - source select bit picks pixel clock
// - reference multiplied by two-bit field
// - reference clock within 25 to 154 MHz
// - dsi clock divided by five-bit field
// - software programs clock range fields
// - pll enable only after clock settings
// - registers stay accessible during ulps
// - ulps entry on all enabled lanes
// - after ulps exit wait, soft reset
// - pattern enable drives pattern, ignores dsi
// - three pattern modes, geometry from registers
// - enable low means shutdown and float
// - enable held low at least 10 ms
// - in reset: clock hs, lanes lp11
// - no bridging before configuration writes
// - soft reset, wait, then video, wait
// - clear errors with 0xFF, read later
// - nonzero errors restart from lane setup
// - all waits are minimums only
`timescale 1ns/1ps
`default_nettype none
module bcr_ctrl #(
	parameter int RESET_CYC = bcr_pkg::RESET_CYC, // 10 ms wait
	parameter int ULPS_CYC  = bcr_pkg::ULPS_CYC,  // 3 ms wait
	parameter int VIDEO_CYC = bcr_pkg::VIDEO_CYC, // 5 ms wait
	parameter int ERR_CYC   = bcr_pkg::ERR_CYC    // 1 ms wait
) (
	bcr_link_if.ctl          lnk,       // link to bridge
	input  wire logic        pclk,      // system clock
	input  wire logic        presetn,   // async reset, low
	input  wire logic        clk_en,    // freezes state when low
	input  wire logic        psel,      // apb select
	input  wire logic        penable,   // apb access phase
	input  wire logic        pwrite,    // apb write
	input  wire logic [7:0]  paddr,     // apb byte address
	input  wire logic [31:0] pwdata,    // apb write data
	output logic [31:0]      prdata,    // apb read data
	output logic             pready,    // apb ready
	output logic             pslverr,   // apb error
	input  wire logic        vid_in_v,  // user video valid
	input  wire logic [23:0] vid_in_d,  // user video pixel
	input  wire logic [7:0]  err_in     // user dsi error events
);
	import bcr_pkg::*;
	typedef enum logic [15:0] {
		S_IDLE  = 16'h0001,
		S_LANES = 16'h0002,
		S_ENLO  = 16'h0004,
		S_ENHI  = 16'h0008,
		S_TAB   = 16'h0010,
		S_PLL   = 16'h0020,
		S_PLLW  = 16'h0040,
		S_SRST  = 16'h0080,
		S_SRSTW = 16'h0100,
		S_VIDW  = 16'h0200,
		S_ECLR  = 16'h0400,
		S_EWAIT = 16'h0800,
		S_ERD   = 16'h1000,
		S_RUN   = 16'h2000,
		S_ULPS  = 16'h4000,
		S_UEXIT = 16'h8000
	} bcr_state_t;
	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	bcr_state_t  st_reg, st_next;
	logic [15:0] tab [0:TAB_N-1];
	logic [4:0]  len_reg;
	logic        chk_reg;
	logic [7:0]  erd_reg;
	logic [7:0]  retry_reg;
	logic        fail_reg;
	logic        acc, wr, hit;
	logic        go, u_in, u_out;
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign hit     = paddr == R_CTRL || paddr == R_CFG ||
		paddr == R_STAT || paddr == R_ERRRD ||
		(paddr >= R_TAB && paddr < R_TAB + 8'(TAB_N * 4));
	assign pready  = 1'b1;
	assign pslverr = acc & (~hit | (paddr[1:0] != 2'h0));
	assign go      = wr & paddr == R_CTRL & pwdata[0];
	assign u_in    = wr & paddr == R_CTRL & pwdata[1];
	assign u_out   = wr & paddr == R_CTRL & pwdata[2];
	// configuration table and options
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < TAB_N; i++) tab[i] <= 16'h0000;
			len_reg <= 5'h00;
			chk_reg <= 1'b0;
		end else if (clk_en && wr && !pslverr) begin
			if (paddr == R_CFG) begin
				len_reg <= (pwdata[4:0] > 5'(TAB_N)) ? 5'(TAB_N)
					: pwdata[4:0];
				chk_reg <= pwdata[8];
			end
			if (paddr >= R_TAB)
				tab[4'(paddr[5:2])] <= pwdata[15:0];
		end
	end
	// read mux
	always_comb begin
		prdata = 32'h00000000;
		case (paddr)
			R_CFG: prdata = {23'h000000, chk_reg, 3'h0, len_reg};
			R_STAT: prdata = {retry_reg, 7'h00, fail_reg, st_reg};
			R_ERRRD: prdata = {24'h000000, erd_reg};
			default: if (paddr >= R_TAB && hit)
				prdata = {16'h0000, tab[4'(paddr[5:2])]};
		endcase
	end
	// ---------------------------------------------------------------
	// register requests over the link
	// ---------------------------------------------------------------
	logic       req_reg, we_reg;
	logic [7:0] addr_reg, wdata_reg;
	logic [3:0] idx_reg;
	logic       issue, done_op;
	logic [7:0] op_a, op_d;
	assign issue   = st_reg == S_TAB || st_reg == S_PLL ||
		st_reg == S_SRST || st_reg == S_ECLR || st_reg == S_ERD;
	assign done_op = req_reg & lnk.ack;
	assign lnk.req   = req_reg;
	assign lnk.we    = we_reg;
	assign lnk.addr  = addr_reg;
	assign lnk.wdata = wdata_reg;
	// address and data of the next request
	always_comb begin
		op_a = tab[idx_reg][15:8];
		op_d = tab[idx_reg][7:0];
		case (st_reg)
			S_PLL: begin
				op_a = A_PLL;
				op_d = 8'h01;
			end
			S_SRST: begin
				op_a = A_SRST;
				op_d = 8'h01;
			end
			S_ECLR: begin
				op_a = A_ERR;
				op_d = ERR_CLR;
			end
			S_ERD: begin
				op_a = A_ERR;
				op_d = ERR_NONE;
			end
			default: ;
		endcase
	end
	// one request at a time, released at its answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_reg   <= 1'b0;
			we_reg    <= 1'b0;
			addr_reg  <= 8'h00;
			wdata_reg <= 8'h00;
		end else if (clk_en) begin
			if (done_op) begin
				req_reg <= 1'b0;
			end else if (!req_reg && issue) begin
				req_reg   <= 1'b1;
				we_reg    <= st_reg != S_ERD;
				addr_reg  <= op_a;
				wdata_reg <= op_d;
			end
		end
	end
	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic [23:0] cnt_reg;
	logic        resume_reg;
	function automatic logic elapsed(input logic [23:0] c,
		input int n);
		elapsed = c >= 24'(n - 1);
	endfunction
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			S_IDLE: if (go) st_next = S_LANES;
			S_LANES: st_next = S_ENLO;
			S_ENLO: if (elapsed(cnt_reg, RESET_CYC))
				st_next = S_ENHI;
			S_ENHI: if (elapsed(cnt_reg, RESET_CYC))
				st_next = (len_reg == 5'h00) ? S_PLL : S_TAB;
			S_TAB: if (done_op && 5'(idx_reg) + 5'h01 >= len_reg)
				st_next = S_PLL;
			S_PLL: if (done_op) st_next = S_PLLW;
			S_PLLW: if (elapsed(cnt_reg, RESET_CYC)) st_next = S_SRST;
			S_SRST: if (done_op)
				st_next = resume_reg ? S_RUN : S_SRSTW;
			S_SRSTW: if (elapsed(cnt_reg, RESET_CYC))
				st_next = S_VIDW;
			S_VIDW: if (elapsed(cnt_reg, VIDEO_CYC))
				st_next = chk_reg ? S_ECLR : S_RUN;
			S_ECLR: if (done_op) st_next = S_EWAIT;
			S_EWAIT: if (elapsed(cnt_reg, ERR_CYC)) st_next = S_ERD;
			S_ERD: if (done_op)
				st_next = (lnk.rdata != ERR_NONE) ? S_LANES
					: S_RUN;
			S_RUN: begin
				if (go) st_next = S_LANES;
				else if (u_in) st_next = S_ULPS;
			end
			S_ULPS: if (u_out) st_next = S_UEXIT;
			S_UEXIT: if (elapsed(cnt_reg, ULPS_CYC))
				st_next = S_SRST;
			default: st_next = S_IDLE;
		endcase
	end
	// state, wait counter and table index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg  <= S_IDLE;
			cnt_reg <= 24'h000000;
			idx_reg <= 4'h0;
		end else if (clk_en) begin
			st_reg  <= st_next;
			cnt_reg <= (st_next != st_reg) ? 24'h000000
				: cnt_reg + 24'h000001;
			if (st_reg != S_TAB)
				idx_reg <= 4'h0;
			else if (done_op)
				idx_reg <= idx_reg + 4'h1;
		end
	end
	// status: retries, error readback, ulps resume flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erd_reg    <= 8'h00;
			retry_reg  <= 8'h00;
			fail_reg   <= 1'b0;
			resume_reg <= 1'b0;
		end else if (clk_en) begin
			if (st_reg == S_ERD && done_op) begin
				erd_reg <= lnk.rdata;
				if (lnk.rdata != ERR_NONE) begin
					fail_reg  <= 1'b1;
					retry_reg <= retry_reg + 8'h01;
				end
			end else if (go) begin
				fail_reg  <= 1'b0;
				retry_reg <= 8'h00;
			end
			if (st_reg == S_UEXIT)
				resume_reg <= 1'b1;
			else if (st_reg == S_RUN || st_reg == S_LANES)
				resume_reg <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// pin and lane drive
	// ---------------------------------------------------------------
	logic        en_reg, hs_reg, vv_reg;
	logic [1:0]  lane_reg;
	logic [23:0] vd_reg;
	logic [7:0]  err_reg;
	logic        stream;
	assign stream = st_next == S_VIDW || st_next == S_ECLR ||
		st_next == S_EWAIT || st_next == S_ERD || st_next == S_RUN;
	assign lnk.en        = en_reg;
	assign lnk.clk_hs    = hs_reg;
	assign lnk.lane      = lane_reg;
	assign lnk.vid_valid = vv_reg;
	assign lnk.vid_data  = vd_reg;
	assign lnk.dsi_err   = err_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg   <= 1'b0;
			hs_reg   <= 1'b0;
			lane_reg <= LN_LP11;
			vv_reg   <= 1'b0;
			vd_reg   <= 24'h000000;
			err_reg  <= 8'h00;
		end else if (clk_en) begin
			en_reg   <= !(st_next == S_IDLE || st_next == S_LANES ||
				st_next == S_ENLO);
			hs_reg   <= st_next != S_IDLE && st_next != S_ULPS;
			lane_reg <= (st_next == S_ULPS) ? LN_ULPS
				: stream ? LN_HS : LN_LP11;
			vv_reg   <= stream & vid_in_v;
			vd_reg   <= stream ? vid_in_d : 24'h000000;
			err_reg  <= en_reg ? err_in : 8'h00;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bcr_link_if.sv
// link between controller and bridge: enable pin, register port,
// dsi lane states and video stream; one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface bcr_link_if;
	logic        en;          // enable pin, low holds bridge in reset
	logic        req;         // register request
	logic        we;          // write when high
	logic [7:0]  addr;        // register offset
	logic [7:0]  wdata;       // write data
	logic [7:0]  rdata;       // read data
	logic        ack;         // one-cycle answer
	logic        clk_hs;      // dsi clock lane in high speed
	logic [1:0]  lane;        // dsi data lane state
	logic        vid_valid;   // video word valid
	logic [23:0] vid_data;    // video pixel
	logic [7:0]  dsi_err;     // error event pulses on the dsi side
	modport ctl (output en, req, we, addr, wdata, clk_hs, lane,
		vid_valid, vid_data, dsi_err, input rdata, ack);
	modport dev (input en, req, we, addr, wdata, clk_hs, lane,
		vid_valid, vid_data, dsi_err, output rdata, ack);
endinterface
`default_nettype wire

// >>> rtl/bcr_pkg.sv
// constants shared by the bridge and its initialization controller
// assumes one 100 MHz clock for both ends
package bcr_pkg;
	// ---------------------------------------------------------------
	// bridge register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] A_SRST    = 8'h09;
	localparam logic [7:0] A_CLKSRC  = 8'h0A;
	localparam logic [7:0] A_CLKDIV  = 8'h0B;
	localparam logic [7:0] A_PLL     = 8'h0D;
	localparam logic [7:0] A_DSIRNG  = 8'h12;
	localparam logic [7:0] A_HLEN_L  = 8'h20;
	localparam logic [7:0] A_HLEN_H  = 8'h21;
	localparam logic [7:0] A_VSIZE_L = 8'h24;
	localparam logic [7:0] A_VSIZE_H = 8'h25;
	localparam logic [7:0] A_HSW_L   = 8'h2C;
	localparam logic [7:0] A_HSW_H   = 8'h2D;
	localparam logic [7:0] A_VSW_L   = 8'h30;
	localparam logic [7:0] A_VSW_H   = 8'h31;
	localparam logic [7:0] A_HBP     = 8'h34;
	localparam logic [7:0] A_VBP     = 8'h36;
	localparam logic [7:0] A_HFP     = 8'h38;
	localparam logic [7:0] A_VFP     = 8'h3A;
	localparam logic [7:0] A_TPG     = 8'h3C;
	localparam logic [7:0] A_ERR     = 8'hE5;
	// ---------------------------------------------------------------
	// field positions and values
	// ---------------------------------------------------------------
	localparam int         SRC_BIT   = 0;
	localparam logic       SRC_DSI   = 1'b1;
	localparam int         MULT_LSB  = 0;
	localparam int         DIV_LSB   = 3;
	localparam int         PLL_BIT   = 0;
	localparam int         SRST_BIT  = 0;
	localparam int         TPG_EN    = 4;
	localparam int         TPG_M_LSB = 0;
	localparam logic [7:0] ERR_CLR   = 8'hFF;
	localparam logic [7:0] ERR_NONE  = 8'h00;
	localparam logic [7:0] RST_BYTE  = 8'h00;
	// data lane states
	localparam logic [1:0] LN_LP11   = 2'h0;
	localparam logic [1:0] LN_HS     = 2'h1;
	localparam logic [1:0] LN_ULPS   = 2'h2;
	// ---------------------------------------------------------------
	// controller apb map
	// ---------------------------------------------------------------
	localparam logic [7:0] R_CTRL    = 8'h00;
	localparam logic [7:0] R_CFG     = 8'h04;
	localparam logic [7:0] R_STAT    = 8'h08;
	localparam logic [7:0] R_ERRRD   = 8'h0C;
	localparam logic [7:0] R_TAB     = 8'h40;
	localparam int         TAB_N     = 16;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int T_RESET_MS = 10;
	localparam int T_ULPS_MS  = 3;
	localparam int T_VIDEO_MS = 5;
	localparam int T_ERR_MS   = 1;
	localparam int CLK_MHZ    = 100;
	localparam int CYC_MS     = CLK_MHZ * 1000;
	localparam int RESET_CYC  = T_RESET_MS * CYC_MS;
	localparam int ULPS_CYC   = T_ULPS_MS * CYC_MS;
	localparam int VIDEO_CYC  = T_VIDEO_MS * CYC_MS;
	localparam int ERR_CYC    = T_ERR_MS * CYC_MS;
endpackage
